/* File: sram_host_defs.vh */
`ifndef SRAM_HOST_DEFS_VH
`define SRAM_HOST_DEFS_VH
// ===========================================================
// widths
`define ADDR_W 17
`define DATA_W 8
// ===========================================================
// times in ns and clock period in ps
`define CLK_PS 5000
`define T_RC_NS 45
`define T_WC_NS 45
`define T_PWE_NS 35
`define T_SD_NS 25
`define T_DOE_NS 22
`define T_HZ_NS 18
// least times round up to whole cycles
`define RD_CYC ((`T_RC_NS*1000+`CLK_PS-1)/`CLK_PS)
`define WE_CYC ((`T_PWE_NS*1000+`CLK_PS-1)/`CLK_PS)
`define WC_CYC ((`T_WC_NS*1000+`CLK_PS-1)/`CLK_PS)
`define HZ_CYC ((`T_HZ_NS*1000+`CLK_PS-1)/`CLK_PS)
// timer load values: RD_CYC, WE_CYC and HZ_CYC above less one, sized for the timer; WR_END_LOAD is set on its own
`define RD_LOAD 4'h8
`define HZ_LOAD 4'h3
`define WE_LOAD 4'h6
`define WR_END_LOAD 4'h1
// ===========================================================
// state codes
`define ST_IDLE 3'h0
`define ST_RD 3'h1
`define ST_WR_SETUP 3'h2
`define ST_WR 3'h3
`define ST_WR_END 3'h4
`define ST_TURN 3'h5
`define CNT_W 4
`endif

/* File: cycle_timer.v */
`timescale 1ns/1ps
// ===========================================================
// down counter: done when it reaches zero
module cycle_timer (
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // control
   input wire load,
   input wire [3:0] load_value,
   output wire done
);
   reg [3:0] count_reg;
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 4'h0;
      end else if (load) begin
         count_reg <= load_value;
      end else if (count_reg != 4'h0) begin
         count_reg <= count_reg - 4'h1;
      end
   end
   assign done = (count_reg == 4'h0);
endmodule // cycle_timer

/* File: sram_host.v */
`timescale 1ns/1ps
`include "sram_host_defs.vh"
// How it works
// R01: device selected only when primary low, secondary high
// R02: write lasts while strobe and select overlap
// R03: data held stable past the ending edge
// R04: gate high keeps device data lines floating
// R05: deselect with strobe rise causes no drive
// R06: host never drives while device drives data
// R07: strobe stays high through every read
// R08: address valid before select goes active; the code drives address and select on the same edge
// R09: held-selected read returns data per address
// R10: strobe, gate and select choose device mode
module sram_host (
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // user request side
   input wire req_valid,
   input wire req_write,
   input wire [16:0] req_addr,
   input wire [7:0] req_wdata,
   output reg req_ready,
   output reg rsp_valid,
   output reg [7:0] rsp_rdata,
   // memory pins
   output reg [16:0] mem_addr,
   output reg primary_select_n,
   output reg secondary_select,
   output reg write_strobe_n,
   output reg output_gate_n,
   input wire [7:0] mem_data_in,
   output reg [7:0] mem_data_out,
   output reg mem_data_oe
);
   // ===========================================================
   // state
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg timer_load;
   reg [3:0] timer_value;
   wire timer_done;
   reg hold_sel;
   // look-ahead timer runs one count ahead, so ready can lead the read's end
   wire [3:0] ahead_value;
   wire ahead_done;
   reg ready_next;

   cycle_timer u_timer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .load(timer_load),
      .load_value(timer_value),
      .done(timer_done)
   );

   cycle_timer u_ahead (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .load(timer_load),
      .load_value(ahead_value),
      .done(ahead_done)
   );
   assign ahead_value = (timer_value == 4'h0) ? 4'h0 : timer_value - 4'h1;

   // ===========================================================
   // next state and timer loads
   always @* begin
      state_next = state_reg;
      timer_load = 1'b0;
      timer_value = 4'h0;
      hold_sel = 1'b0;
      case (state_reg)
         `ST_IDLE: begin
            if (req_valid && req_ready) begin
               timer_load = 1'b1;
               if (req_write) begin
                  state_next = `ST_WR_SETUP;
                  timer_value = 4'h0;
               end else begin
                  state_next = `ST_RD;
                  timer_value = `RD_LOAD;
               end
            end
         end
         `ST_RD: begin
            if (timer_done) begin
               // select kept for back to back reads, address driven
               if (req_valid && req_ready && !req_write) begin
                  hold_sel = 1'b1;
                  timer_load = 1'b1;
                  timer_value = `RD_LOAD;
               end else begin
                  state_next = `ST_TURN;
                  timer_load = 1'b1;
                  timer_value = `HZ_LOAD;
               end
            end
         end
         `ST_WR_SETUP: begin
            state_next = `ST_WR;
            timer_load = 1'b1;
            timer_value = `WE_LOAD;
         end
         `ST_WR: begin
            if (timer_done) begin
               state_next = `ST_WR_END;
               timer_load = 1'b1;
               timer_value = `WR_END_LOAD;
            end
         end
         `ST_WR_END: begin
            if (timer_done) begin
               state_next = `ST_IDLE;
            end
         end
         `ST_TURN: begin
            if (timer_done) begin
               state_next = `ST_IDLE;
            end
         end
         default: begin
            state_next = `ST_IDLE;
         end
      endcase
   end

   // ===========================================================
   // request ready
   // ready is a flop, so it is raised one edge early: in idle, and in the last
   // count of a read when another read waits, which the held select then takes
   // limitation: a waiting read must not turn into a write while ready stands
   always @* begin
      ready_next = 1'b0;
      if (state_next == `ST_IDLE) begin
         ready_next = 1'b1;
      end else if (state_next == `ST_RD && !timer_load && ahead_done) begin
         ready_next = req_valid && !req_write; // R09
      end
   end

   // ===========================================================
   // pin and response registers
   // every pin is a flop output so the device sees clean edges
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= `ST_IDLE;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         mem_addr <= 17'h00000;
         primary_select_n <= 1'b1;
         secondary_select <= 1'b0;
         write_strobe_n <= 1'b1;
         output_gate_n <= 1'b1;
         mem_data_out <= 8'h00;
         mem_data_oe <= 1'b0;
      end else begin
         state_reg <= state_next;
         rsp_valid <= 1'b0;
         req_ready <= ready_next;
         case (state_reg)
            `ST_IDLE: begin
               if (state_next == `ST_RD) begin
                  // address goes out with the select, never after it
                  mem_addr <= req_addr; // R08
                  primary_select_n <= 1'b0; // R01
                  secondary_select <= 1'b1; // R01
                  write_strobe_n <= 1'b1; // R07
                  output_gate_n <= 1'b0; // R10
                  mem_data_oe <= 1'b0; // R06
               end else if (state_next == `ST_WR_SETUP) begin
                  // gate stays high through the write so the device never drives
                  mem_addr <= req_addr;
                  mem_data_out <= req_wdata;
                  output_gate_n <= 1'b1; // R04
                  mem_data_oe <= 1'b1; // R06
                  primary_select_n <= 1'b0; // R01
                  secondary_select <= 1'b1; // R01
               end
            end
            `ST_RD: begin
               if (timer_done) begin
                  rsp_valid <= 1'b1;
                  rsp_rdata <= mem_data_in;
                  if (hold_sel) begin
                     // new address alone brings new data
                     mem_addr <= req_addr; // R09
                  end else begin
                     primary_select_n <= 1'b1; // R10
                     secondary_select <= 1'b0;
                     output_gate_n <= 1'b1; // R04
                  end
               end
            end
            `ST_WR_SETUP: begin
               // strobe falls after address is stable; the overlap starts the write
               write_strobe_n <= 1'b0; // R02
            end
            `ST_WR: begin
               if (timer_done) begin
                  // strobe ends the write; select stays a cycle longer and data two cycles longer
                  write_strobe_n <= 1'b1; // R02 R03
               end
            end
            `ST_WR_END: begin
               // deselect strictly after strobe rise, gate already high
               primary_select_n <= 1'b1; // R05
               secondary_select <= 1'b0;
               if (timer_done) begin
                  mem_data_oe <= 1'b0; // R03
               end
            end
            `ST_TURN: begin
               // wait out the device's release of the bus
               mem_data_oe <= 1'b0; // R06
            end
            default: begin
               mem_data_oe <= 1'b0;
            end
         endcase
      end
   end
endmodule // sram_host

/* File: sram_dev_model.sv */
`timescale 1ns/1ps
`include "sram_host_defs.vh"
// ===========================================================
// memory device seen from the host pins
module sram_dev_model (
   // pins from the host
   input wire [16:0] mem_addr,
   input wire primary_select_n,
   input wire secondary_select,
   input wire write_strobe_n,
   input wire output_gate_n,
   input wire [7:0] host_data,
   input wire host_oe,
   // data back to the host
   output wire [7:0] mem_data_in
);
   reg [7:0] mem [0:131071];
   reg [7:0] last = 8'h00;
   wire sel = !primary_select_n && secondary_select;
   wire drive = sel && write_strobe_n && !output_gate_n;
   wire [7:0] rd = mem[mem_addr];
   // an undriven host bus stores garbage, not the last good byte
   wire [7:0] wdat = host_oe ? host_data : ~host_data;
   always @* if (sel && !write_strobe_n) mem[mem_addr] = wdat;
   always @* if (drive) last = rd;
   // data counts as valid only once pins have been still for the access time,
   // one ns short of it so the sampling edge does not race the model
   wire [17:0] access_key = {drive, mem_addr};
   wire [17:0] access_late;
   assign #(`T_RC_NS - 1) access_late = access_key;
   wire settled = drive && (access_late == access_key);
   // floating or unsettled lines show the inverse so stale data never passes
   assign mem_data_in = settled ? rd : ~last;
endmodule // sram_dev_model

/* File: sram_host_props.sv */
`timescale 1ns/1ps
// ===========================================================
// pin protocol checks on the host side
module sram_host_props (
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // memory pins
   input wire [16:0] mem_addr,
   input wire primary_select_n,
   input wire secondary_select,
   input wire write_strobe_n,
   input wire output_gate_n,
   input wire [7:0] mem_data_out,
   input wire mem_data_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire sel = !primary_select_n && secondary_select;
   sequence s_pulse; !write_strobe_n [*7] ##1 write_strobe_n; endsequence
   sequence s_release; sel ##1 !sel; endsequence
   property p_wr_start; $fell(write_strobe_n) |-> sel && mem_data_oe; endproperty
   a_wr_start: assert property (p_wr_start) else $error("strobe without select");
   property p_wr_end; $fell(write_strobe_n) |-> s_pulse ##0 s_release; endproperty
   a_wr_end: assert property (p_wr_end) else $error("write end order");
   property p_hold; !write_strobe_n |=> $stable(mem_data_out) && $stable(mem_addr) && mem_data_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("write data moved");
   property p_no_fight; sel && !output_gate_n |-> !mem_data_oe; endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus contention");
   property p_rd_strobe; !output_gate_n |-> write_strobe_n; endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("strobe low in read");
   property p_addr_first; $rose(sel) |=> $stable(mem_addr); endproperty
   a_addr_first: assert property (p_addr_first) else $error("address late");
   sequence s_quiet; !mem_data_oe [*4]; endsequence
   property p_turn; $rose(output_gate_n) |-> s_quiet; endproperty
   a_turn: assert property (p_turn) else $error("host drove during release");
endmodule // sram_host_props
bind sram_host sram_host_props i_sram_host_props (.ref_clk, .reset_n, .mem_addr,
   .primary_select_n, .secondary_select, .write_strobe_n, .output_gate_n, .mem_data_out,
   .mem_data_oe);

/* File: async_sram_port_control_tb.sv */
`timescale 1ns/1ps
// ===========================================================
// testbench
module async_sram_port_control_tb;
   reg ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   reg [16:0] req_addr = 17'h00000;
   reg [7:0] req_wdata = 8'h00;
   wire req_ready, rsp_valid, primary_select_n, secondary_select, write_strobe_n;
   wire output_gate_n, mem_data_oe;
   wire [7:0] rsp_rdata, mem_data_in, mem_data_out;
   wire [16:0] mem_addr;
   integer fail_count = 0, n_tests = 0, cycles = 0;
   reg [7:0] rq [$];
   sram_host i_sram_host (.ref_clk, .reset_n, .req_valid, .req_write, .req_addr,
      .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .primary_select_n,
      .secondary_select, .write_strobe_n, .output_gate_n, .mem_data_in, .mem_data_out,
      .mem_data_oe);
   sram_dev_model i_sram_dev_model (.mem_addr, .primary_select_n, .secondary_select,
      .write_strobe_n, .output_gate_n, .host_data(mem_data_out), .host_oe(mem_data_oe),
      .mem_data_in);
   initial forever #2.5 ref_clk = ~ref_clk;
   // ===========================================================
   // response capture mid-cycle, where the one-cycle pulse stands; hang limit
   always @(negedge ref_clk) begin
      if (rsp_valid === 1'b1) rq.push_back(rsp_rdata);
      cycles = cycles + 1;
      if (cycles == 3000) begin
         fail_count = fail_count + 1;
         final_report;
      end
   end
   task final_report;
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task req(input w, input [16:0] a, input [7:0] d, input keep);
      integer i;
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(posedge ref_clk) #1;
      n_tests++;
      if (req_ready !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED req_ready expected 1 seen %b", req_ready);
      end
      @(posedge ref_clk) #1;
      n_tests++;
      if (req_ready !== 1'b0) begin
         fail_count++;
         $display("CHECK FAILED req_ready after take expected 0 seen %b", req_ready);
      end
      // a dropped request lets an edge pass so the next call never lands in this step
      if (!keep) begin
         req_valid = 1'b0;
         @(posedge ref_clk) #1;
      end
   endtask
   task expect_rsp(input [7:0] e);
      integer i;
      for (i = 0; i < 30 && rq.size() == 0; i++) @(posedge ref_clk) #1;
      n_tests++;
      if (rq.size() == 0 || rq[0] !== e) begin
         fail_count++;
         $display("CHECK FAILED rsp_rdata expected %h seen %h", e, rq.size() ? rq[0] : 8'hxx);
      end
      if (rq.size() != 0) rq.delete(0);
   endtask
   // ===========================================================
   // scenarios
   task scn_edges;
      req(1'b1, 17'h00000, 8'h5a, 1'b0);
      req(1'b1, 17'h1ffff, 8'ha5, 1'b0);
      req(1'b0, 17'h00000, 8'h00, 1'b0);
      expect_rsp(8'h5a);
      req(1'b0, 17'h1ffff, 8'h00, 1'b0);
      expect_rsp(8'ha5);
   endtask
   task scn_held_read;
      req(1'b1, 17'h0aaaa, 8'h3c, 1'b0);
      req(1'b0, 17'h1ffff, 8'h00, 1'b1);
      req(1'b0, 17'h0aaaa, 8'h00, 1'b0);
      expect_rsp(8'ha5);
      expect_rsp(8'h3c);
   endtask
   task scn_turn;
      req(1'b0, 17'h0aaaa, 8'h00, 1'b0);
      req(1'b1, 17'h0aaaa, 8'hc3, 1'b0);
      expect_rsp(8'h3c);
      req(1'b0, 17'h0aaaa, 8'h00, 1'b0);
      expect_rsp(8'hc3);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (2) @(posedge ref_clk) #1;
      scn_edges;
      scn_held_read;
      scn_turn;
      final_report;
   end
endmodule // async_sram_port_control_tb
